// *** design/tis_char_decode.v ***
// Tape character decoder: format select and parity check.
`timescale 1ns/1ps
`default_nettype none
`include "tis_map.vh"

module tis_char_decode (
    input  wire [`TIS_RAW_W-1:0]  raw,
    input  wire                   fmt_8ch,
    output reg  [`TIS_CODE_W-1:0] code,
    output reg                    par_ok,
    output reg                    is_digit,
    output reg                    is_sep,
    output reg                    is_letter
);

    always @* begin
        if (fmt_8ch) begin
            code   = raw[`TIS_CH8_MSB:0];
            // Odd parity over all eight channels
            par_ok = ((^raw) == `TIS_PAR_ODD);
        end else begin
            // Five channels carry no parity, so nothing to check
            code   = {1'b0, raw[`TIS_CH5_MSB:0]};
            par_ok = 1'b1;
        end
        is_digit  = (code <= `TIS_DIG_MAX);
        is_sep    = (code == `TIS_SEP_CODE);
        is_letter = (code >= `TIS_LET_MIN);
    end

endmodule // tis_char_decode
`default_nettype wire

// *** design/tis_map.vh ***
// Constants for the tape input sequencer: codes, widths, states.
`ifndef TIS_MAP_VH
`define TIS_MAP_VH

// Tape character framing
`define TIS_RAW_W        8
`define TIS_CODE_W       6
`define TIS_CH5_MSB      4
`define TIS_CH8_MSB      5
`define TIS_PAR_ODD      1'b1

// Character codes after decode
`define TIS_DIG_MAX      6'h09
`define TIS_SEP_CODE     6'h0a
`define TIS_LET_MIN      6'h10
`define TIS_OP_U         6'h1e
`define TIS_OP_C         6'h13

// Word layout
`define TIS_DIGITS       4'hc
`define TIS_DIG_W        4
`define TIS_WORD_W       48
`define TIS_INSTR_W      18
`define TIS_ICH_FIRST    2'h0
`define TIS_ICH_SECOND   2'h1
`define TIS_ICH_THIRD    2'h2

// One-hot states
`define TIS_ST_W         5
`define TIS_ST_IDLE      5'h01
`define TIS_ST_RDNUM     5'h02
`define TIS_ST_TFETCH    5'h04
`define TIS_ST_TWAIT     5'h08
`define TIS_ST_HALT      5'h10

`endif

// *** design/tis_top.v ***
// Tape input sequencer: read-number and pass-control to tape.
`timescale 1ns/1ps
`default_nettype none
`include "tis_map.vh"

module tis_top (
    input  wire                   clk,
    input  wire                   reset_n,
    input  wire                   fmt_8ch,
    input  wire                   cmd_read_num,
    input  wire                   cmd_pass_ctl,
    input  wire                   instr_done,
    input  wire                   panel_clear,
    input  wire                   char_valid,
    input  wire [`TIS_RAW_W-1:0]  char_data,
    output reg                    char_ready_q,
    output reg                    busy_q,
    output reg                    tape_ctl_q,
    output reg                    acc_load_q,
    output reg  [`TIS_WORD_W-1:0] acc_word_q,
    output reg                    seq_resume_q,
    output reg                    instr_valid_q,
    output reg  [`TIS_INSTR_W-1:0] instr_word_q,
    output reg                    instr_xfer_q,
    output reg                    check_alarm_q,
    output reg                    fmt_err_q
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    reg  [`TIS_ST_W-1:0]   state_q;
    reg  [1:0]             ich_q;
    reg  [`TIS_CODE_W-1:0] op_q;
    reg  [`TIS_CODE_W-1:0] arg_q;

    wire [`TIS_CODE_W-1:0] code;
    wire                   par_ok;
    wire                   is_digit;
    wire                   is_sep;
    wire                   is_letter;
    wire [`TIS_WORD_W-1:0] asm_word;
    wire [3:0]             asm_cnt;
    wire                   asm_full;

    wire                   take;
    wire                   good;
    wire                   st_idle;
    wire                   st_rdnum;
    wire                   st_tfetch;
    wire                   data_phase;
    wire                   word_pending;
    wire                   word_end;
    wire                   asm_push;
    wire                   asm_clr;
    wire                   is_xfer_op;

    ////////////////////////////////////////////////////////////////////////
    // Character path

    tis_char_decode u_dec (
        .raw       (char_data),
        .fmt_8ch   (fmt_8ch),
        .code      (code),
        .par_ok    (par_ok),
        .is_digit  (is_digit),
        .is_sep    (is_sep),
        .is_letter (is_letter)
    );

    assign take      = char_valid && char_ready_q;
    assign good      = take && par_ok;
    assign st_idle   = (state_q == `TIS_ST_IDLE);
    assign st_rdnum  = (state_q == `TIS_ST_RDNUM);
    assign st_tfetch = (state_q == `TIS_ST_TFETCH);

    // Between instructions a digit starts or extends a data word
    assign data_phase   = st_rdnum || (st_tfetch && ich_q == `TIS_ICH_FIRST);
    assign word_pending = (asm_cnt != 4'h0);

    // A word ends at a separator, or under tape control at a letter too
    assign word_end = good && data_phase && word_pending &&
                      (is_sep || (st_tfetch && is_letter));

    assign asm_push = good && data_phase && is_digit && !asm_full;
    assign asm_clr  = st_idle || word_end;

    tis_word_asm u_asm (
        .clk     (clk),
        .reset_n (reset_n),
        .clr     (asm_clr),
        .push    (asm_push),
        .digit   (code[`TIS_DIG_W-1:0]),
        .word_q  (asm_word),
        .cnt_q   (asm_cnt),
        .full    (asm_full)
    );

    // Transfers that hand control back to the pinboards
    assign is_xfer_op = (op_q == `TIS_OP_U) || (op_q == `TIS_OP_C);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always @(posedge clk) begin
        if (!reset_n) begin
            state_q       <= `TIS_ST_IDLE;
            ich_q         <= `TIS_ICH_FIRST;
            op_q          <= {`TIS_CODE_W{1'b0}};
            arg_q         <= {`TIS_CODE_W{1'b0}};
            char_ready_q  <= 1'b0;
            busy_q        <= 1'b0;
            tape_ctl_q    <= 1'b0;
            acc_load_q    <= 1'b0;
            acc_word_q    <= {`TIS_WORD_W{1'b0}};
            seq_resume_q  <= 1'b0;
            instr_valid_q <= 1'b0;
            instr_word_q  <= {`TIS_INSTR_W{1'b0}};
            instr_xfer_q  <= 1'b0;
            check_alarm_q <= 1'b0;
            fmt_err_q     <= 1'b0;
        end else begin
            acc_load_q    <= 1'b0;
            seq_resume_q  <= 1'b0;
            instr_valid_q <= 1'b0;
            instr_xfer_q  <= 1'b0;

            // Whole-word load into the accumulator, digit order kept
            if (word_end) begin
                acc_word_q <= asm_word;
                acc_load_q <= 1'b1;
            end

            case (state_q)
                `TIS_ST_IDLE: begin
                    ich_q <= `TIS_ICH_FIRST;
                    if (cmd_read_num) begin
                        state_q      <= `TIS_ST_RDNUM;
                        char_ready_q <= 1'b1;
                        busy_q       <= 1'b1;
                    end else if (cmd_pass_ctl) begin
                        // No step condition: any pinboard step may ask
                        state_q      <= `TIS_ST_TFETCH;
                        char_ready_q <= 1'b1;
                        busy_q       <= 1'b1;
                        tape_ctl_q   <= 1'b1;
                    end
                end

                `TIS_ST_RDNUM: begin
                    if (take && !par_ok) begin
                        state_q       <= `TIS_ST_HALT;
                        char_ready_q  <= 1'b0;
                        check_alarm_q <= 1'b1;
                    end else if (good && is_digit && asm_full) begin
                        // Thirteenth digit: tape is malformed
                        state_q      <= `TIS_ST_HALT;
                        char_ready_q <= 1'b0;
                        fmt_err_q    <= 1'b1;
                    end else if (good && is_letter) begin
                        state_q      <= `TIS_ST_HALT;
                        char_ready_q <= 1'b0;
                        fmt_err_q    <= 1'b1;
                    end else if (word_end) begin
                        // Control stays with the pinboards
                        state_q      <= `TIS_ST_IDLE;
                        char_ready_q <= 1'b0;
                        busy_q       <= 1'b0;
                        seq_resume_q <= 1'b1;
                    end
                end

                `TIS_ST_TFETCH: begin
                    if (take && !par_ok) begin
                        state_q       <= `TIS_ST_HALT;
                        char_ready_q  <= 1'b0;
                        check_alarm_q <= 1'b1;
                    end else if (good) begin
                        case (ich_q)
                            `TIS_ICH_FIRST: begin
                                if (is_digit && asm_full) begin
                                    state_q      <= `TIS_ST_HALT;
                                    char_ready_q <= 1'b0;
                                    fmt_err_q    <= 1'b1;
                                end else if (is_letter) begin
                                    op_q  <= code;
                                    ich_q <= `TIS_ICH_SECOND;
                                end
                            end
                            `TIS_ICH_SECOND: begin
                                if (is_sep) begin
                                    // Short instruction: preparer failed
                                    state_q      <= `TIS_ST_HALT;
                                    char_ready_q <= 1'b0;
                                    fmt_err_q    <= 1'b1;
                                end else begin
                                    arg_q <= code;
                                    ich_q <= `TIS_ICH_THIRD;
                                end
                            end
                            `TIS_ICH_THIRD: begin
                                if (is_sep) begin
                                    state_q      <= `TIS_ST_HALT;
                                    char_ready_q <= 1'b0;
                                    fmt_err_q    <= 1'b1;
                                end else begin
                                    // Third character completes it
                                    instr_word_q  <= {op_q, arg_q, code};
                                    instr_valid_q <= 1'b1;
                                    ich_q         <= `TIS_ICH_FIRST;
                                    char_ready_q  <= 1'b0;
                                    if (is_xfer_op) begin
                                        instr_xfer_q <= 1'b1;
                                        tape_ctl_q   <= 1'b0;
                                        busy_q       <= 1'b0;
                                        state_q      <= `TIS_ST_IDLE;
                                    end else begin
                                        state_q <= `TIS_ST_TWAIT;
                                    end
                                end
                            end
                            default: begin
                                ich_q <= `TIS_ICH_FIRST;
                            end
                        endcase
                    end
                end

                `TIS_ST_TWAIT: begin
                    // Hold tape still until the sequencer has executed it
                    if (instr_done) begin
                        state_q      <= `TIS_ST_TFETCH;
                        char_ready_q <= 1'b1;
                    end
                end

                `TIS_ST_HALT: begin
                    // Only the panel clear leaves a stop
                    char_ready_q <= 1'b0;
                    if (panel_clear) begin
                        state_q       <= `TIS_ST_IDLE;
                        busy_q        <= 1'b0;
                        tape_ctl_q    <= 1'b0;
                        check_alarm_q <= 1'b0;
                        fmt_err_q     <= 1'b0;
                        ich_q         <= `TIS_ICH_FIRST;
                    end
                end

                default: begin
                    state_q      <= `TIS_ST_IDLE;
                    char_ready_q <= 1'b0;
                    busy_q       <= 1'b0;
                    tape_ctl_q   <= 1'b0;
                end
            endcase
        end
    end

endmodule // tis_top
`default_nettype wire

// *** design/tis_word_asm.v ***
// Decimal word assembler: shifts digits in from the right.
`timescale 1ns/1ps
`default_nettype none
`include "tis_map.vh"

module tis_word_asm (
    input  wire                   clk,
    input  wire                   reset_n,
    input  wire                   clr,
    input  wire                   push,
    input  wire [`TIS_DIG_W-1:0]  digit,
    output reg  [`TIS_WORD_W-1:0] word_q,
    output reg  [3:0]             cnt_q,
    output wire                   full
);

    assign full = (cnt_q == `TIS_DIGITS);

    always @(posedge clk) begin
        if (!reset_n) begin
            word_q <= {`TIS_WORD_W{1'b0}};
            cnt_q  <= 4'h0;
        end else if (clr) begin
            word_q <= {`TIS_WORD_W{1'b0}};
            cnt_q  <= 4'h0;
        end else if (push && !full) begin
            // Cleared word plus left shift gives zero padding on the left
            word_q <= {word_q[`TIS_WORD_W-`TIS_DIG_W-1:0], digit};
            cnt_q  <= cnt_q + 4'h1;
        end
    end

endmodule // tis_word_asm
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench of the tape input sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "tis_map.vh"

module testbench;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        fmt_8ch = 1'b1;
    logic        cmd_read_num = 1'b0;
    logic        cmd_pass_ctl = 1'b0;
    logic        instr_done = 1'b0;
    logic        panel_clear = 1'b0;
    logic        stall_en = 1'b0;
    logic        char_valid;
    logic [7:0]  char_data;
    logic        char_ready_q, busy_q, tape_ctl_q, acc_load_q, seq_resume_q;
    logic        instr_valid_q, instr_xfer_q, check_alarm_q, fmt_err_q;
    logic [47:0] acc_word_q;
    logic [17:0] instr_word_q;
    logic [48:0] exp_q[$];
    logic [48:0] note;
    logic        alarm_seen;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cycles = 0;

    always #20 clk = ~clk;

    tis_top tis_top_inst (.clk(clk), .reset_n(reset_n), .fmt_8ch(fmt_8ch),
        .cmd_read_num(cmd_read_num), .cmd_pass_ctl(cmd_pass_ctl),
        .instr_done(instr_done), .panel_clear(panel_clear),
        .char_valid(char_valid), .char_data(char_data),
        .char_ready_q(char_ready_q), .busy_q(busy_q), .tape_ctl_q(tape_ctl_q),
        .acc_load_q(acc_load_q), .acc_word_q(acc_word_q),
        .seq_resume_q(seq_resume_q), .instr_valid_q(instr_valid_q),
        .instr_word_q(instr_word_q), .instr_xfer_q(instr_xfer_q),
        .check_alarm_q(check_alarm_q), .fmt_err_q(fmt_err_q));

    tis_tape_reader reader (.clk(clk), .char_ready_q(char_ready_q),
        .stall_en(stall_en), .char_valid(char_valid), .char_data(char_data));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [48:0] seen, input logic [48:0] want);
        tests_run++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Upper bits of five-channel characters are junk on purpose
    task automatic put(input logic [5:0] c, input logic bad);
        logic [7:0] r;
        r = {3'($urandom_range(0, 7)), c[4:0]};
        if (fmt_8ch)
            r = {~^c ^ bad, 1'b0, c};
        reader.load(r);
    endtask

    task automatic num(input int len, input logic lead);
        logic [47:0] w;
        logic [3:0]  d;
        w = 48'h0;
        if (lead)
            put(`TIS_SEP_CODE, 1'b0);
        repeat (len) begin
            d = 4'($urandom_range(0, 9));
            w = {w[43:0], d};
            put({2'h0, d}, 1'b0);
        end
        put(`TIS_SEP_CODE, 1'b0);
        exp_q.push_back({1'b0, w});
    endtask

    task automatic instr(input logic [5:0] op);
        put(op, 1'b0);
        put(6'h01, 1'b0);
        put(6'h01, 1'b0);
        exp_q.push_back({1'b1, 29'h0,
            op == `TIS_OP_U || op == `TIS_OP_C, op, 12'h041});
    endtask

    task automatic run(input logic rd, input logic alarm);
        int n;
        alarm_seen = 1'b0;
        cmd_read_num = rd;
        cmd_pass_ctl = ~rd;
        @(posedge clk);
        #1;
        cmd_read_num = 1'b0;
        cmd_pass_ctl = 1'b0;
        check({48'h0, busy_q & (tape_ctl_q ^ rd)}, 49'h1);
        for (n = 0; n < 3000 && busy_q === 1'b1; n++) begin
            @(posedge clk);
            #1;
            panel_clear = check_alarm_q;
            if (check_alarm_q === 1'b1)
                alarm_seen = 1'b1;
        end
        panel_clear = 1'b0;
        check({48'h0, alarm_seen}, {48'h0, alarm});
        check({46'h0, fmt_err_q, busy_q, tape_ctl_q}, 49'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (acc_load_q === 1'b1) begin
            note = exp_q.pop_front();
            check({1'b0, acc_word_q}, note);
        end else if (instr_valid_q === 1'b1) begin
            note = exp_q.pop_front();
            check({1'b1, 29'h0, instr_xfer_q, instr_word_q}, note);
            // Sequencer takes a while; tape must wait for it
            if (instr_xfer_q !== 1'b1) begin
                repeat ($urandom_range(1, 4)) @(posedge clk);
                #1 instr_done = 1'b1;
                @(posedge clk);
                #1 instr_done = 1'b0;
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        int k;
        void'($urandom(32'he312));
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        for (k = 0; k < 6; k++) begin
            fmt_8ch = k < 3;
            stall_en = k[0];
            num(k % 3 == 0 ? 1 : k % 3 == 1 ? 12 : $urandom_range(2, 11), 1'b1);
            run(1'b1, 1'b0);
        end
        for (k = 0; k < 2; k++) begin
            fmt_8ch = k == 0;
            num(3, 1'b0);
            instr(6'h11);
            num(12, 1'b0);
            instr(6'h1b);
            instr(k ? `TIS_OP_C : `TIS_OP_U);
            num(5, 1'b0);
            run(1'b0, 1'b0);
            run(1'b1, 1'b0);
        end
        fmt_8ch = 1'b1;
        put(6'h07, 1'b0);
        put(6'h03, 1'b1);
        run(1'b1, 1'b1);
        repeat (8) @(posedge clk);
        check({17'h0, 32'(exp_q.size())}, 49'h0);
        final_report();
    end
endmodule // testbench

bind tis_top tis_chk tis_chk_inst (.clk(clk), .reset_n(reset_n),
    .cmd_read_num(cmd_read_num), .cmd_pass_ctl(cmd_pass_ctl),
    .panel_clear(panel_clear), .char_ready_q(char_ready_q), .busy_q(busy_q),
    .tape_ctl_q(tape_ctl_q), .acc_load_q(acc_load_q),
    .seq_resume_q(seq_resume_q), .instr_valid_q(instr_valid_q),
    .instr_xfer_q(instr_xfer_q), .check_alarm_q(check_alarm_q));

`default_nettype wire

// *** testbench/tis_tape_reader.sv ***
// Behavioural paper tape reader feeding the sequencer.
`timescale 1ns/1ps
`default_nettype none

module tis_tape_reader (
    input  wire logic       clk,
    input  wire logic       char_ready_q,
    input  wire logic       stall_en,
    output var  logic       char_valid,
    output var  logic [7:0] char_data
);
    logic [7:0] tape_q[$];
    logic       taken;

    initial begin
        char_valid = 1'b0;
        char_data = 8'h00;
    end

    task automatic load(input logic [7:0] ch);
        tape_q.push_back(ch);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Characters leave in tape order, each held until taken
    always @(posedge clk) begin
        taken = char_valid && char_ready_q;
        if (taken)
            void'(tape_q.pop_front());
        #1;
        if (taken || !char_valid) begin
            if (tape_q.size() > 0 && !(stall_en && $urandom_range(0, 2) == 0))
            begin
                char_valid = 1'b1;
                char_data = tape_q[0];
            end else begin
                // Idle line wanders so stale data cannot pass as good
                char_valid = 1'b0;
                char_data = ~char_data;
            end
        end
    end
endmodule // tis_tape_reader

`default_nettype wire

// *** testbench/tis_top_asserts.sv ***
// Port checker for the tape input sequencer.
`timescale 1ns/1ps
`default_nettype none

module tis_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_read_num,
    input wire logic cmd_pass_ctl,
    input wire logic panel_clear,
    input wire logic char_ready_q,
    input wire logic busy_q,
    input wire logic tape_ctl_q,
    input wire logic acc_load_q,
    input wire logic seq_resume_q,
    input wire logic instr_valid_q,
    input wire logic instr_xfer_q,
    input wire logic check_alarm_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    read_accept_a: assert property (!busy_q && cmd_read_num |=>
        busy_q && char_ready_q && !tape_ctl_q) else $error("read not taken");
    pass_accept_a: assert property (
        !busy_q && cmd_pass_ctl && !cmd_read_num |=>
        busy_q && tape_ctl_q && char_ready_q) else $error("pass not taken");
    resume_done_a: assert property (seq_resume_q |->
        acc_load_q && !busy_q && !tape_ctl_q) else $error("bad resume");
    tape_load_a: assert property (acc_load_q && !seq_resume_q |->
        tape_ctl_q && busy_q) else $error("tape data left tape control");
    instr_keep_a: assert property (instr_valid_q && !instr_xfer_q |->
        tape_ctl_q && !char_ready_q) else $error("bad plain instruction");
    // A new command may be taken right after, so look in the same cycle
    xfer_return_a: assert property (instr_xfer_q |->
        instr_valid_q && !tape_ctl_q && !busy_q) else $error("bad xfer");
    ctl_drop_a: assert property ($fell(tape_ctl_q) |->
        instr_xfer_q || $past(instr_xfer_q) || $past(panel_clear))
        else $error("tape control lost without transfer");
    alarm_halt_a: assert property ($rose(check_alarm_q) |->
        !char_ready_q && busy_q) else $error("alarm did not halt");
    alarm_hold_a: assert property (check_alarm_q && !panel_clear |=>
        check_alarm_q) else $error("alarm dropped without clear");

    read_done_c: cover property (seq_resume_q);
    xfer_c:      cover property (instr_xfer_q);
    alarm_c:     cover property ($rose(check_alarm_q));
endmodule // tis_chk

`default_nettype wire
